// >>> ekuc_regs.svh
/*
 * constants for the effect knob controller: register map, field
 * positions, reset values and timing counts. assumes a 100 MHz clock.
 */
`ifndef EKUC_REGS_SVH
`define EKUC_REGS_SVH

`define EKUC_CLK_MHZ 100
`define EKUC_MS2CYC(ms) ((ms) * `EKUC_CLK_MHZ * 1000)
`define EKUC_DEBOUNCE_MS 5
`define EKUC_DBL_GAP_MS 300
`define EKUC_HOLD_MS 2000
`define EKUC_IDLE_MS 10000
`define EKUC_FLASH_MS 250

`define EKUC_OFS_CTRL 8'h00
`define EKUC_OFS_STATUS 8'h04
`define EKUC_OFS_TUNE 8'h08
`define EKUC_CTRL_RESET 3'h0
`define EKUC_CH_NUM 3'h4
`define EKUC_ST_LMODE 4
`define EKUC_ST_RMODE 6
`define EKUC_ST_FX1 8
`define EKUC_ST_FX2 16
`define EKUC_ST_BYP 24
`define EKUC_TUNE_CENTS 4

`define EKUC_AMT_MID 4'h4
`define EKUC_AMT_MAX 4'h8
`define EKUC_SER_MAX 5'h0e
`define EKUC_PAR_MAX 5'h11
`define EKUC_ENT_DEF 3'h5
`define EKUC_ENT_BACK 3'h6
`define EKUC_ITEM_SAVE 3'h0
`define EKUC_ITEM_RECALL 3'h1
`define EKUC_ITEM_BACK 3'h2

`endif

// >>> ekuc_pkg.sv
/*
 * types for the effect knob controller.
 * assumes ekuc_regs.svh for all numeric constants.
 */
package ekuc_pkg;
	typedef enum logic [2:0] {G_IDLE, G_DOWN, G_HELD, G_GAP, G_DOWN2} ekuc_gest_e;
	typedef enum logic [1:0] {L_NORM, L_SEL, L_TUNE} ekuc_lmode_e;
	typedef enum logic [1:0] {R_NORM, R_SEL, R_LIST, R_SUB} ekuc_rmode_e;
	typedef enum logic [2:0] {K_NONE, K_FX, K_NOTE, K_SLOT, K_MENU} ekuc_kind_e;
	typedef struct packed {
		ekuc_kind_e kind;
		logic [4:0] val;
	} ekuc_disp_s;
	typedef struct packed {
		logic [3:0][3:0] series_effect_slot;
		logic [1:0][4:0] parallel_effect_slot;
		logic [3:0][3:0] amt1;
		logic [3:0][3:0] amt2;
		logic [3:0][3:0] ext;
		logic [3:0] byp1;
		logic [3:0] byp2;
		logic [3:0] xmute;
	} ekuc_cfg_s;
endpackage

// >>> ekuc_ctrl.sv
/*
 * effect knob controller: gesture decode for three push knobs, effect
 * selection, bypass, tuner, snapshot menu, loop level, LED and strip drive.
 * assumes knob pins are asynchronous and an AXI4-Lite master on CLOCK.
 */
`timescale 1ns/1ns
`include "ekuc_regs.svh"

// Contract
// - with a channel selected, a single tap enters effect choice for that knob
// - choice state flashes ring yellow and strip at one rate
// - rotation browses effects; a press commits the browsed effect to the strip
// - choice state stays while active; ends after ten idle seconds or a tap on the current effect
// - any committed effect sets that channel's amount to the midpoint
// - outside choice state rotation sets the amount from off to max
// - series codes 0-14, parallel 0-17; 6, 13 and parallel 14 only on channels 2, 4
// - double tap bypasses: ring flashes, strip solid, amount ignored; tap re-engages
// - at reset left knob runs the series effect, right knob the parallel effect
// - series effect slot is held per channel
// - parallel effect slot is shared by channels 1+3 and 2+4
// - each channel keeps its own effect levels
// - two second left hold mutes channel, starts tuner, swaps indicators
// - tuner shows note on strip, ring lit centre, left flat, right sharp
// - tuner ends after ten idle seconds or a single tap
// - two second right hold enters snapshots: effects muted, indicators swap
// - snapshot strip alternates none and slot; rotation walks slots, default, back
// - snapshots end after ten idle seconds or a tap on the back entry
// - slot push offers save, recall, back; save or recall returns to normal
// - default entry offers recall of factory settings or back
// - while browsing, LEDs show stored settings of the selected channel; the loop ring keeps showing the live return level
// - loop knob sets return level per channel, default off, first LED lit
module ekuc_ctrl #(
	parameter int DEB_CYC = `EKUC_MS2CYC(`EKUC_DEBOUNCE_MS),
	parameter int GAP_CYC = `EKUC_MS2CYC(`EKUC_DBL_GAP_MS),
	parameter int HOLD_CYC = `EKUC_MS2CYC(`EKUC_HOLD_MS),
	parameter int IDLE_CYC = `EKUC_MS2CYC(`EKUC_IDLE_MS),
	parameter int FLASH_CYC = `EKUC_MS2CYC(`EKUC_FLASH_MS)
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [2:0] KNOB_PRESS,
	input wire logic [2:0] KNOB_A,
	input wire logic [2:0] KNOB_B,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	output logic [8:0] RING_L,
	output logic [8:0] RING_R,
	output logic [8:0] RING_X,
	output logic RING_L_YEL,
	output logic RING_R_YEL,
	output logic IND_SERIES,
	output logic IND_TUNER,
	output logic IND_PARALLEL,
	output logic IND_SNAP,
	output ekuc_pkg::ekuc_disp_s DISP_L,
	output ekuc_pkg::ekuc_disp_s DISP_R,
	output logic DISP_L_ON,
	output logic DISP_R_ON,
	output logic [3:0] CH_MUTE,
	output logic FX_MUTE,
	output ekuc_pkg::ekuc_cfg_s CFG
);
	localparam ekuc_pkg::ekuc_cfg_s FACT = '{
		series_effect_slot: '0, parallel_effect_slot: '0,
		amt1: {4{`EKUC_AMT_MID}}, amt2: {4{`EKUC_AMT_MID}},
		ext: '0, byp1: '0, byp2: '0, xmute: '0};

	if (GAP_CYC < 1 || DEB_CYC < 1 || HOLD_CYC <= DEB_CYC || IDLE_CYC < 1 || FLASH_CYC < 1) begin
		$error("ekuc_ctrl: timing parameters out of range");
	end

	logic [2:0] p1, p2, a1, a2, a3, b1, b2;
	logic deb [3];
	logic [31:0] dcnt [3];
	logic [31:0] gcnt [3];
	ekuc_pkg::ekuc_gest_e gst [3];
	logic tap [3];
	logic dbl [3];
	logic hold [3];
	logic cw [3];
	logic ccw [3];
	ekuc_pkg::ekuc_lmode_e lmode;
	ekuc_pkg::ekuc_rmode_e rmode;
	ekuc_pkg::ekuc_cfg_s cfg;
	ekuc_pkg::ekuc_cfg_s snap [5];
	ekuc_pkg::ekuc_cfg_s view;
	logic [4:0] lbr, rbr;
	logic [2:0] idx, sub, item;
	logic [31:0] ltm, rtm, fcnt;
	logic flash, lto, rto, lact, ract, chv, pair, l_commit;
	logic [2:0] ch_reg;
	logic [1:0] ch;
	logic [7:0] tune;
	logic aw_got, w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// two-stage synchronisers for all knob pins
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			{p1, p2, a1, a2, a3, b1, b2} <= '0;
		end else begin
			p1 <= KNOB_PRESS;
			p2 <= p1;
			a1 <= KNOB_A;
			a2 <= a1;
			a3 <= a2;
			b1 <= KNOB_B;
			b2 <= b1;
		end
	end

	// per-knob debounce, rotation step and gesture classifier
	for (genvar g = 0; g < 3; g++) begin : knob
		always_ff @(posedge CLOCK or posedge RST) begin
			if (RST) begin
				deb[g] <= 1'b0;
				dcnt[g] <= '0;
			end else if (p2[g] == deb[g]) begin
				dcnt[g] <= '0;
			end else if (dcnt[g] == 32'(DEB_CYC - 1)) begin
				deb[g] <= p2[g];
				dcnt[g] <= '0;
			end else begin
				dcnt[g] <= dcnt[g] + 32'h1;
			end
		end
		always_ff @(posedge CLOCK or posedge RST) begin
			if (RST) begin
				cw[g] <= 1'b0;
				ccw[g] <= 1'b0;
			end else begin
				cw[g] <= a2[g] && !a3[g] && !b2[g];
				ccw[g] <= a2[g] && !a3[g] && b2[g];
			end
		end
		// each gesture fires exactly one pulse
		always_ff @(posedge CLOCK or posedge RST) begin
			if (RST) begin
				gst[g] <= ekuc_pkg::G_IDLE;
				gcnt[g] <= '0;
				{tap[g], dbl[g], hold[g]} <= 3'h0;
			end else begin
				{tap[g], dbl[g], hold[g]} <= 3'h0;
				gcnt[g] <= gcnt[g] + 32'h1;
				case (gst[g])
					ekuc_pkg::G_IDLE: if (deb[g]) begin
						gst[g] <= ekuc_pkg::G_DOWN;
						gcnt[g] <= '0;
					end
					ekuc_pkg::G_DOWN: if (!deb[g]) begin
						gst[g] <= ekuc_pkg::G_GAP;
						gcnt[g] <= '0;
					end else if (gcnt[g] == 32'(HOLD_CYC - 1)) begin
						hold[g] <= 1'b1;
						gst[g] <= ekuc_pkg::G_HELD;
					end
					ekuc_pkg::G_HELD: if (!deb[g]) begin
						gst[g] <= ekuc_pkg::G_IDLE;
					end
					ekuc_pkg::G_GAP: if (deb[g]) begin
						gst[g] <= ekuc_pkg::G_DOWN2;
					end else if (gcnt[g] == 32'(GAP_CYC - 1)) begin
						tap[g] <= 1'b1;
						gst[g] <= ekuc_pkg::G_IDLE;
					end
					ekuc_pkg::G_DOWN2: if (!deb[g]) begin
						dbl[g] <= 1'b1;
						gst[g] <= ekuc_pkg::G_IDLE;
					end
					default: gst[g] <= ekuc_pkg::G_IDLE;
				endcase
			end
		end
	end

	// restricted codes exist only on channels 2 and 4
	function automatic logic ekuc_avail(input logic ser, input logic [4:0] c,
			input logic [1:0] chn);
		logic r;
		r = ser ? (c == 5'h06 || c == 5'h0d) : (c == 5'h0e);
		return !r || chn[0];
	endfunction

	// one browse step, skipping codes this channel cannot use
	function automatic logic [4:0] ekuc_step(input logic [4:0] c, input logic up,
			input logic [4:0] mx, input logic ser, input logic [1:0] chn);
		logic [4:0] n;
		n = c;
		for (int k = 0; k < 2; k++) begin
			if (k == 0 || !ekuc_avail(ser, n, chn)) begin
				if (up && n < mx) n = n + 5'h01;
				else if (!up && n != 5'h00) n = n - 5'h01;
			end
		end
		return n;
	endfunction

	function automatic logic [3:0] ekuc_adj(input logic [3:0] v, input logic up,
			input logic dn);
		if (up && v < `EKUC_AMT_MAX) return v + 4'h1;
		if (dn && v != 4'h0) return v - 4'h1;
		return v;
	endfunction

	function automatic logic [8:0] ekuc_bar(input logic [3:0] v);
		logic [8:0] b;
		b = '0;
		for (int k = 0; k < 9; k++) b[k] = (4'(k) <= v);
		return b;
	endfunction

	assign ch = ch_reg[1:0];
	assign chv = ch_reg < `EKUC_CH_NUM;
	assign pair = ch[0];
	assign lact = tap[0] || dbl[0] || hold[0] || cw[0] || ccw[0];
	assign ract = tap[1] || dbl[1] || hold[1] || cw[1] || ccw[1];
	assign lto = ltm == 32'(IDLE_CYC - 1);
	assign rto = rtm == 32'(IDLE_CYC - 1);
	assign item = (idx == `EKUC_ENT_DEF) ? sub + 3'h1 : sub;
	assign view = (idx < `EKUC_ENT_DEF) ? snap[idx] : FACT;
	assign l_commit = lmode == ekuc_pkg::L_SEL && chv && !lto && !cw[0] && !ccw[0]
		&& tap[0] && lbr[3:0] != cfg.series_effect_slot[ch];

	// idle timers, each cleared by activity on its own knob
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ltm <= '0;
			rtm <= '0;
		end else begin
			ltm <= (lmode == ekuc_pkg::L_NORM || lact) ? '0 : (lto ? ltm : ltm + 32'h1);
			rtm <= (rmode == ekuc_pkg::R_NORM || ract) ? '0 : (rto ? rtm : rtm + 32'h1);
		end
	end

	// flash rate shared by rings and strips
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			fcnt <= '0;
			flash <= 1'b0;
		end else if (fcnt == 32'(FLASH_CYC - 1)) begin
			fcnt <= '0;
			flash <= !flash;
		end else begin
			fcnt <= fcnt + 32'h1;
		end
	end

	// knob modes, settings and snapshot memory
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			lmode <= ekuc_pkg::L_NORM;
			rmode <= ekuc_pkg::R_NORM;
			lbr <= '0;
			rbr <= '0;
			idx <= '0;
			sub <= '0;
			cfg <= FACT;
			for (int k = 0; k < 5; k++) snap[k] <= FACT;
		end else begin
			case (lmode)
				ekuc_pkg::L_NORM: if (chv) begin
					if (tap[0] && cfg.byp1[ch]) begin
						cfg.byp1[ch] <= 1'b0;
					end else if (tap[0]) begin
						lmode <= ekuc_pkg::L_SEL;
						lbr <= {1'b0, cfg.series_effect_slot[ch]};
					end else if (dbl[0]) begin
						cfg.byp1[ch] <= !cfg.byp1[ch];
					end else if (hold[0]) begin
						lmode <= ekuc_pkg::L_TUNE;
					end else if (!cfg.byp1[ch]) begin
						cfg.amt1[ch] <= ekuc_adj(cfg.amt1[ch], cw[0], ccw[0]);
					end
				end
				ekuc_pkg::L_SEL: if (lto || !chv) begin
					lmode <= ekuc_pkg::L_NORM;
				end else if (cw[0] || ccw[0]) begin
					lbr <= ekuc_step(lbr, cw[0], `EKUC_SER_MAX, 1'b1, ch);
				end else if (l_commit) begin
					cfg.series_effect_slot[ch] <= lbr[3:0];
					cfg.amt1[ch] <= `EKUC_AMT_MID;
				end else if (tap[0]) begin
					lmode <= ekuc_pkg::L_NORM;
				end
				ekuc_pkg::L_TUNE: if (lto || tap[0]) begin
					lmode <= ekuc_pkg::L_NORM;
				end
				default: lmode <= ekuc_pkg::L_NORM;
			endcase
			case (rmode)
				ekuc_pkg::R_NORM: if (chv) begin
					if (tap[1] && cfg.byp2[ch]) begin
						cfg.byp2[ch] <= 1'b0;
					end else if (tap[1]) begin
						rmode <= ekuc_pkg::R_SEL;
						rbr <= cfg.parallel_effect_slot[pair];
					end else if (dbl[1]) begin
						cfg.byp2[ch] <= !cfg.byp2[ch];
					end else if (hold[1]) begin
						rmode <= ekuc_pkg::R_LIST;
						idx <= '0;
					end else if (!cfg.byp2[ch]) begin
						cfg.amt2[ch] <= ekuc_adj(cfg.amt2[ch], cw[1], ccw[1]);
					end
				end
				ekuc_pkg::R_SEL: if (rto || !chv) begin
					rmode <= ekuc_pkg::R_NORM;
				end else if (cw[1] || ccw[1]) begin
					rbr <= ekuc_step(rbr, cw[1], `EKUC_PAR_MAX, 1'b0, ch);
				end else if (tap[1] && rbr != cfg.parallel_effect_slot[pair]) begin
					cfg.parallel_effect_slot[pair] <= rbr;
					cfg.amt2[ch] <= `EKUC_AMT_MID;
				end else if (tap[1]) begin
					rmode <= ekuc_pkg::R_NORM;
				end
				ekuc_pkg::R_LIST: if (rto) begin
					rmode <= ekuc_pkg::R_NORM;
				end else if (cw[1] && idx < `EKUC_ENT_BACK) begin
					idx <= idx + 3'h1;
				end else if (ccw[1] && idx != 3'h0) begin
					idx <= idx - 3'h1;
				end else if (tap[1] && idx == `EKUC_ENT_BACK) begin
					rmode <= ekuc_pkg::R_NORM;
				end else if (tap[1]) begin
					rmode <= ekuc_pkg::R_SUB;
					sub <= '0;
				end
				ekuc_pkg::R_SUB: if (rto) begin
					rmode <= ekuc_pkg::R_NORM;
				end else if (cw[1] && item < `EKUC_ITEM_BACK) begin
					sub <= sub + 3'h1;
				end else if (ccw[1] && sub != 3'h0) begin
					sub <= sub - 3'h1;
				end else if (tap[1] && item == `EKUC_ITEM_SAVE) begin
					snap[idx] <= cfg;
					rmode <= ekuc_pkg::R_NORM;
				end else if (tap[1] && item == `EKUC_ITEM_RECALL) begin
					rmode <= ekuc_pkg::R_NORM;
				end else if (tap[1]) begin
					rmode <= ekuc_pkg::R_LIST;
				end
				default: rmode <= ekuc_pkg::R_NORM;
			endcase
			if (chv && tap[2] && cfg.xmute[ch]) begin
				cfg.xmute[ch] <= 1'b0;
			end else if (chv && dbl[2]) begin
				cfg.xmute[ch] <= !cfg.xmute[ch];
			end else if (chv && !cfg.xmute[ch]) begin
				cfg.ext[ch] <= ekuc_adj(cfg.ext[ch], cw[2], ccw[2]);
			end
			// recall replaces every setting, so it is applied last
			if (rmode == ekuc_pkg::R_SUB && !rto && !cw[1] && !(ccw[1] && sub != 3'h0)
					&& tap[1] && item == `EKUC_ITEM_RECALL) begin
				cfg <= view;
			end
		end
	end

	// rings, strips, indicators and mutes, all registered
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			{RING_L, RING_R, RING_X} <= '0;
			{RING_L_YEL, RING_R_YEL, IND_TUNER, IND_SNAP, FX_MUTE} <= '0;
			{IND_SERIES, IND_PARALLEL, DISP_L_ON, DISP_R_ON} <= 4'hf;
			DISP_L <= '{ekuc_pkg::K_NONE, 5'h00};
			DISP_R <= '{ekuc_pkg::K_NONE, 5'h00};
			CH_MUTE <= '0;
			CFG <= FACT;
		end else begin
			CFG <= cfg;
			RING_L_YEL <= lmode == ekuc_pkg::L_SEL;
			RING_R_YEL <= rmode == ekuc_pkg::R_SEL;
			IND_TUNER <= lmode == ekuc_pkg::L_TUNE;
			IND_SERIES <= lmode != ekuc_pkg::L_TUNE;
			IND_SNAP <= rmode >= ekuc_pkg::R_LIST;
			IND_PARALLEL <= rmode < ekuc_pkg::R_LIST;
			FX_MUTE <= rmode >= ekuc_pkg::R_LIST;
			CH_MUTE <= (lmode == ekuc_pkg::L_TUNE && chv) ? 4'h1 << ch : 4'h0;
			RING_X <= !chv ? 9'h000 : ekuc_bar(cfg.ext[ch]) & {9{!cfg.xmute[ch] || flash}};
			DISP_L_ON <= lmode != ekuc_pkg::L_SEL || flash;
			DISP_R_ON <= rmode != ekuc_pkg::R_SEL || flash;
			if (!chv) begin
				RING_L <= '0;
				DISP_L <= '{ekuc_pkg::K_NONE, 5'h00};
			end else if (lmode == ekuc_pkg::L_TUNE) begin
				RING_L <= 9'h001 << 4'(4'sh4 + $signed(tune[7:4]));
				DISP_L <= '{ekuc_pkg::K_NOTE, {1'b0, tune[3:0]}};
			end else if (rmode >= ekuc_pkg::R_LIST) begin
				RING_L <= ekuc_bar(view.amt1[ch]);
				DISP_L <= '{ekuc_pkg::K_FX, {1'b0, view.series_effect_slot[ch]}};
			end else begin
				RING_L <= ekuc_bar(cfg.amt1[ch])
					& {9{!(cfg.byp1[ch] || lmode == ekuc_pkg::L_SEL) || flash}};
				DISP_L <= '{ekuc_pkg::K_FX, (lmode == ekuc_pkg::L_SEL) ? lbr
					: {1'b0, cfg.series_effect_slot[ch]}};
			end
			if (!chv) begin
				RING_R <= '0;
				DISP_R <= '{ekuc_pkg::K_NONE, 5'h00};
			end else if (rmode == ekuc_pkg::R_LIST) begin
				RING_R <= ekuc_bar(view.amt2[ch]);
				DISP_R <= flash ? '{ekuc_pkg::K_SLOT, {2'h0, idx}}
					: '{ekuc_pkg::K_NONE, 5'h00};
			end else if (rmode == ekuc_pkg::R_SUB) begin
				RING_R <= ekuc_bar(view.amt2[ch]);
				DISP_R <= '{ekuc_pkg::K_MENU, {2'h0, item}};
			end else begin
				RING_R <= ekuc_bar(cfg.amt2[ch])
					& {9{!(cfg.byp2[ch] || rmode == ekuc_pkg::R_SEL) || flash}};
				DISP_R <= '{ekuc_pkg::K_FX, (rmode == ekuc_pkg::R_SEL) ? rbr
					: cfg.parallel_effect_slot[pair]};
			end
		end
	end

	// AXI4-Lite write channel: address and data in either order
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			{AWREADY, WREADY, BVALID, aw_got, w_got} <= '0;
			BRESP <= 2'h0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			ch_reg <= `EKUC_CTRL_RESET;
			tune <= '0;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_got <= 1'b1;
				AWREADY <= 1'b0;
				aw_addr <= AWADDR;
			end else if (!aw_got && !BVALID) begin
				AWREADY <= 1'b1;
			end
			if (WVALID && WREADY) begin
				w_got <= 1'b1;
				WREADY <= 1'b0;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end else if (!w_got && !BVALID) begin
				WREADY <= 1'b1;
			end
			if (aw_got && w_got && !BVALID) begin
				{aw_got, w_got} <= 2'h0;
				BVALID <= 1'b1;
				BRESP <= 2'h0;
				if (aw_addr == `EKUC_OFS_CTRL) begin
					if (w_strb[0]) ch_reg <= w_data[2:0];
				end else if (aw_addr == `EKUC_OFS_TUNE) begin
					if (w_strb[0]) tune <= w_data[7:0];
				end else if (aw_addr != `EKUC_OFS_STATUS) begin
					BRESP <= 2'h2;
				end
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			{ARREADY, RVALID} <= '0;
			RDATA <= '0;
			RRESP <= 2'h0;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RRESP <= 2'h0;
			RDATA <= '0;
			if (ARADDR == `EKUC_OFS_CTRL) begin
				RDATA[2:0] <= ch_reg;
			end else if (ARADDR == `EKUC_OFS_STATUS) begin
				RDATA[2:0] <= ch_reg;
				RDATA[`EKUC_ST_LMODE +: 2] <= lmode;
				RDATA[`EKUC_ST_RMODE +: 2] <= rmode;
				RDATA[`EKUC_ST_FX1 +: 4] <= cfg.series_effect_slot[ch];
				RDATA[`EKUC_ST_FX2 +: 5] <= cfg.parallel_effect_slot[pair];
				RDATA[`EKUC_ST_BYP +: 3] <= {cfg.xmute[ch], cfg.byp2[ch], cfg.byp1[ch]};
			end else if (ARADDR == `EKUC_OFS_TUNE) begin
				RDATA[7:0] <= tune;
			end else begin
				RRESP <= 2'h2;
			end
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end else if (!RVALID) begin
			ARREADY <= 1'b1;
		end
	end

	default clocking dcb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sel_enter_a: assert property (lmode == ekuc_pkg::L_NORM && chv && tap[0] && !cfg.byp1[ch]
		|=> lmode == ekuc_pkg::L_SEL) else $error("tap did not enter effect choice");
	sel_flash_a: assert property (lmode == ekuc_pkg::L_SEL ##1 lmode == ekuc_pkg::L_SEL
		|-> RING_L_YEL && DISP_L_ON == $past(flash)) else $error("choice state not flashing");
	ring_flash_a: assert property (lmode == ekuc_pkg::L_SEL && chv
		&& rmode < ekuc_pkg::R_LIST |=> (RING_L != 9'h000) == $past(flash))
		else $error("choice ring not flashing");
	commit_mid_a: assert property (l_commit && !(rmode == ekuc_pkg::R_SUB && tap[1])
		|=> cfg.amt1[$past(ch)] == `EKUC_AMT_MID
		&& cfg.series_effect_slot[$past(ch)] == $past(lbr[3:0])) else $error("commit lost");
	idle_exit_a: assert property (lmode != ekuc_pkg::L_NORM && lto && !tap[0]
		|=> lmode == ekuc_pkg::L_NORM) else $error("idle timeout ignored");
	code_range_a: assert property (cfg.series_effect_slot[0] != 4'h6
		&& cfg.series_effect_slot[0] != 4'hd && cfg.series_effect_slot[2] != 4'h6
		&& cfg.series_effect_slot[2] != 4'hd && cfg.parallel_effect_slot[0] != 5'h0e
		&& cfg.parallel_effect_slot[1] <= `EKUC_PAR_MAX) else $error("bad effect code");
	bypass_hold_a: assert property (lmode == ekuc_pkg::L_NORM && chv && cfg.byp1[ch]
		&& !tap[0] && !dbl[0] && rmode != ekuc_pkg::R_SUB |=> $stable(cfg.amt1))
		else $error("bypassed amount moved");
	tuner_ind_a: assert property (lmode == ekuc_pkg::L_TUNE && chv
		|=> IND_TUNER && !IND_SERIES && CH_MUTE == (4'h1 << $past(ch)))
		else $error("tuner outputs wrong");
	snap_enter_a: assert property (rmode == ekuc_pkg::R_NORM && chv && hold[1]
		&& !tap[1] && !dbl[1] |=> rmode == ekuc_pkg::R_LIST ##1 FX_MUTE && IND_SNAP
		&& !IND_PARALLEL) else $error("snapshot entry wrong");
	gest_once_a: assert property (tap[0] || dbl[0] || hold[0]
		|-> $onehot({tap[0], dbl[0], hold[0]}) ##1 !(tap[0] || dbl[0] || hold[0]))
		else $error("gesture reported twice");

	sel_commit_c: cover property (l_commit);
	tuner_run_c: cover property (lmode == ekuc_pkg::L_TUNE ##1 lmode == ekuc_pkg::L_NORM);
	snap_save_c: cover property (rmode == ekuc_pkg::R_SUB ##1 rmode == ekuc_pkg::R_NORM);
	bypass_c: cover property (dbl[1] ##1 cfg.byp2 != 4'h0);
endmodule

// >>> ekuc_knob_model.sv
/*
 * performer model: pushes and turns the three knobs.
 * assumes the bench clock and calls aligned to a rising edge.
 */
`timescale 1ns/1ns
module ekuc_knob_model (
	input wire logic CLOCK,
	output logic [2:0] KNOB_PRESS,
	output logic [2:0] KNOB_A,
	output logic [2:0] KNOB_B
);
	// knobs at rest
	initial begin
		KNOB_PRESS = 3'h0;
		KNOB_A = 3'h0;
		KNOB_B = 3'h0;
	end
	// press for p edges, then rest for r edges
	task automatic push(input int k, input int p, input int r);
		KNOB_PRESS[k] <= 1'b1;
		repeat (p) @(posedge CLOCK);
		KNOB_PRESS[k] <= 1'b0;
		repeat (r) @(posedge CLOCK);
	endtask
	// detent steps, clockwise has B low at A rise
	task automatic turn(input int k, input logic cw, input int n);
		repeat (n) begin
			KNOB_B[k] <= ~cw;
			repeat (4) @(posedge CLOCK);
			KNOB_A[k] <= 1'b1;
			repeat (6) @(posedge CLOCK);
			KNOB_A[k] <= 1'b0;
			repeat (6) @(posedge CLOCK);
		end
	endtask
endmodule

// >>> tb.sv
/*
 * bench for the effect knob controller: register and knob sequences.
 * assumes the shortened counts DEB 2, GAP 20, HOLD 60, IDLE 200.
 */
`timescale 1ns/1ns
module tb;
	logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, yel_l, yel_r;
	logic ind_s, ind_t, ind_p, ind_n, fx_mute;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, s;
	logic [1:0] rresp, r, bresp;
	logic [3:0] wstrb;
	logic [2:0] kp, ka, kb;
	logic [8:0] ring_l, ring_x;
	logic [3:0] ch_mute;
	ekuc_pkg::ekuc_cfg_s cfg;
	ekuc_pkg::ekuc_disp_s disp_l, disp_r;
	int miscompares = 0;
	int n_tests = 0;
	ekuc_ctrl #(.DEB_CYC(2), .GAP_CYC(20), .HOLD_CYC(60), .IDLE_CYC(200), .FLASH_CYC(4)) uut (
		.CLOCK(clock), .RST(rst), .KNOB_PRESS(kp), .KNOB_A(ka), .KNOB_B(kb),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
		.WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
		.BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.RING_L(ring_l), .RING_R(), .RING_X(ring_x), .RING_L_YEL(yel_l), .RING_R_YEL(yel_r),
		.IND_SERIES(ind_s), .IND_TUNER(ind_t), .IND_PARALLEL(ind_p), .IND_SNAP(ind_n),
		.DISP_L(disp_l), .DISP_R(disp_r), .DISP_L_ON(), .DISP_R_ON(), .CH_MUTE(ch_mute),
		.FX_MUTE(fx_mute), .CFG(cfg));
	ekuc_knob_model knobs (.CLOCK(clock), .KNOB_PRESS(kp), .KNOB_A(ka), .KNOB_B(kb));
	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic guard(input int n);
		if (n >= 50) begin
			miscompares++;
			close_out();
		end
	endtask
	// write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, b;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clock);
			ta = awready;
			tw = wready;
			b = bvalid;
			r = bresp;
			n++;
			@(posedge clock);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!b && n < 50);
		bready <= 1'b0;
		guard(n);
	endtask
	// read: address released when taken, data taken with rvalid
	task automatic axi_rd(input logic [7:0] a);
		int n;
		logic g, v;
		n = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clock);
			g = arready;
			v = rvalid;
			s = rdata;
			r = rresp;
			n++;
			@(posedge clock);
			if (g) arvalid <= 1'b0;
		end while (!v && n < 50);
		rready <= 1'b0;
		guard(n);
	endtask
	task automatic tap(input int k);
		knobs.push(k, 8, 34);
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		check("ind", {ind_s, ind_t, ind_p, ind_n}, 4'ha);
		axi_wr(8'h00, 32'h0);
		check("wr ok", r, 2'h0);
		axi_wr(8'h0c, 32'h1);
		check("wr unmapped", r, 2'h2);
		// write with no byte lane enabled leaves the channel alone
		wstrb <= 4'h0;
		axi_wr(8'h00, 32'h1);
		wstrb <= 4'hf;
		axi_rd(8'h04);
		check("modes", s[7:0], 8'h00);
		axi_rd(8'h0c);
		check("unmapped", r, 2'h2);
		check("loop ring", ring_x, 9'h001);
		tap(0);
		check("yellow", yel_l, 1'b1);
		axi_rd(8'h04);
		check("left mode", s[5:4], 2'h1);
		knobs.turn(0, 1'b1, 6);
		tap(0);
		check("series", cfg.series_effect_slot[0], 32'h7);
		check("amt mid", cfg.amt1[0], 32'h4);
		check("strip", disp_l, {ekuc_pkg::K_FX, 5'h07});
		tap(0);
		check("yellow off", yel_l, 1'b0);
		knobs.turn(0, 1'b1, 2);
		check("amt", cfg.amt1[0], 32'h6);
		check("ring", ring_l, 9'h07f);
		knobs.push(0, 8, 6);
		knobs.push(0, 8, 20);
		check("bypass", cfg.byp1[0], 1'b1);
		knobs.turn(0, 1'b0, 1);
		check("amt held", cfg.amt1[0], 32'h6);
		tap(0);
		check("engaged", cfg.byp1[0], 1'b0);
		axi_wr(8'h00, 32'h2);
		knobs.turn(1, 1'b1, 2);
		check("amt2 up", cfg.amt2[2], 32'h6);
		tap(1);
		check("yellow r", yel_r, 1'b1);
		knobs.turn(1, 1'b1, 1);
		tap(1);
		tap(1);
		check("pair", cfg.parallel_effect_slot[0], 32'h1);
		check("amt2", cfg.amt2[2], 32'h4);
		check("own series", cfg.series_effect_slot[2], 32'h0);
		check("own level", cfg.amt1[2], 32'h4);
		tap(0);
		check("yellow 3", yel_l, 1'b1);
		repeat (240) @(posedge clock);
		check("idle exit", yel_l, 1'b0);
		axi_wr(8'h08, 32'hf3);
		knobs.push(0, 80, 10);
		check("tuner", {ind_s, ind_t, ch_mute}, 6'h14);
		check("flat ring", ring_l, 9'h008);
		check("note", disp_l, {ekuc_pkg::K_NOTE, 5'h03});
		tap(0);
		check("tuner off", ind_t, 1'b0);
		knobs.push(1, 80, 10);
		check("snap", {ind_p, ind_n, fx_mute}, 3'h3);
		repeat (240) @(posedge clock);
		check("snap off", ind_n, 1'b0);
		// save slot 0, move the level, then recall it
		knobs.push(1, 80, 10);
		tap(1);
		check("menu", disp_r, {ekuc_pkg::K_MENU, 5'h00});
		tap(1);
		knobs.turn(1, 1'b1, 2);
		check("amt2 moved", cfg.amt2[2], 32'h6);
		knobs.push(1, 80, 10);
		tap(1);
		knobs.turn(1, 1'b1, 1);
		tap(1);
		check("recall", cfg.amt2[2], 32'h4);
		check("snap done", ind_n, 1'b0);
		knobs.turn(2, 1'b1, 3);
		check("loop", ring_x, 9'h00f);
		close_out();
	end
endmodule
